// *** rtl/acs_seq.sv ***
// Calibration sequencer for a sigma-delta converter: input selection,
// coefficient capture, gain division and result correction.
// Assumes filter, serial port and host bits all run on i_mclk.
//
// Contract
// - Coefficients come from a zero-scale and a full-scale conversion.
// - Correction keeps 33-bit precision; result is 16 or 24 bits.
// - Host may write offset and gain coefficients directly.
// - Subtract offset first, then multiply by gain.
// - Self, system and offset calibrations end with data-ready low.
// - Data-ready rises within one modulator cycle of a calibration command.
// - Mode 001 converts shorted node, then reference, gain from span.
// - Self calibration ends only after coefficients update and resettle.
// - Self calibration runs at the currently selected gain.
// - Bipolar self calibration spans midscale to positive full scale.
// - Mode 010 converts zero scale on the input, then data-ready low.
// - Mode 011 converts full scale on the input, then data-ready low.
// - A lone zero step updates offset and keeps the gain.
// - Unipolar spans endpoints; bipolar spans midscale to full scale.
// - Mode 100 converts input zero, then reference, then data-ready low.
// - Mode 101 interleaves background calibration with conversions.
// - Background mode outputs one result per six conversions.
// - Background mode stays until the mode field is rewritten.
// - First background result is flagged invalid.
// - Every calibration command resets the digital filter.
`timescale 1ns/100ps
`include "acs_defines.svh"

module acs_seq #(
    parameter int MOD_DIV  = `ACS_MOD_DIV,
    parameter int PTS_ONE  = `ACS_PTS_ONE,
    parameter int PTS_SYS  = `ACS_PTS_SYS,
    parameter int BG_SLOTS = `ACS_BG_SLOTS
) (
    input  wire logic                i_mclk,
    input  wire logic                i_srst,
    input  wire logic                i_mode_wr,
    input  wire logic [2:0]          i_mode,
    input  wire logic                i_bipolar,
    input  wire logic                i_word24,
    input  wire logic [2:0]          i_gain,
    input  wire logic [1:0]          i_coef_wr,
    input  wire acs_pkg::acs_coef_t  i_coef_in,
    input  wire logic                i_conv_valid,
    input  wire logic [23:0]         i_conv_code,
    input  wire logic                i_result_read,
    output logic                     o_data_ready_n,
    output acs_pkg::acs_result_t     o_result,
    output acs_pkg::acs_coef_t       o_coef,
    output acs_pkg::acs_src_t        o_src,
    output logic [2:0]               o_pga_gain,
    output logic                     o_filter_rst,
    output logic                     o_cal_busy,
    output logic                     o_bg_active
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic is_cal_code(input logic [2:0] m);
        return (m >= `ACS_MODE_SELF) && (m <= `ACS_MODE_BG);
    endfunction

    function automatic logic [23:0] correct(
        input logic [23:0]        code,
        input acs_pkg::acs_coef_t c,
        input logic               bip,
        input logic               w24
    );
        logic signed [24:0] diff;
        logic signed [49:0] prod;
        logic signed [32:0] acc;
        logic [23:0]        sat;
        diff = $signed({1'b0, code}) - $signed({1'b0, c.offset});
        prod = diff * $signed({1'b0, c.gain});
        acc  = 33'(prod >>> `ACS_FRAC);
        if (bip) begin
            acc = acc + `ACS_MIDSCALE;
        end
        if (acc < 0) begin
            sat = 24'h000000;
        end else if (acc > `ACS_CODE_MAX) begin
            sat = 24'hffffff;
        end else begin
            sat = acc[23:0];
        end
        if (!w24) begin
            sat[7:0] = 8'h00;
        end
        return sat;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    acs_pkg::acs_state_t  state_ff;
    logic [2:0]           mode_ff;
    logic [2:0]           cnt_ff;
    logic [2:0]           slot_ff;
    logic [23:0]          zero_ff;
    acs_pkg::acs_coef_t   coef_ff;
    acs_pkg::acs_result_t res_ff;
    logic                 rdy_n_ff;
    logic                 raise_ff;
    logic                 frst_ff;
    logic                 bg_first_ff;
    logic                 busy_ff;
    logic                 bg_ff;
    logic [2:0]           pga_ff;
    acs_pkg::acs_src_t    src_ff;
    logic [7:0]           mod_cnt_ff;
    logic [23:0]          div_rem_ff;
    logic [23:0]          div_span_ff;
    logic [23:0]          div_base_ff;
    logic [46:0]          div_num_ff;
    logic [46:0]          div_quo_ff;
    logic [5:0]           div_cnt_ff;
    logic                 div_busy_ff;
    logic                 div_done_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic cal_cmd  = i_mode_wr & is_cal_code(i_mode);
    wire logic mod_tick = (mod_cnt_ff == 8'(MOD_DIV - 1));
    wire logic is_sys   = (mode_ff == `ACS_MODE_SYS_Z) ||
                          (mode_ff == `ACS_MODE_SYS_F);
    wire logic last_conv = i_conv_valid &&
        (cnt_ff == (is_sys ? 3'(PTS_SYS - 1) : 3'(PTS_ONE - 1)));
    wire logic bg_last  = (slot_ff == 3'(BG_SLOTS - 1));
    wire logic [23:0] corr =
        correct(i_conv_code, coef_ff, i_bipolar, i_word24);

    wire acs_pkg::acs_state_t entry_state =
        !is_cal_code(i_mode)          ? acs_pkg::ST_NORMAL :
        (i_mode == `ACS_MODE_SYS_F)   ? acs_pkg::ST_FULL   :
        (i_mode == `ACS_MODE_BG)      ? acs_pkg::ST_BG     :
                                        acs_pkg::ST_ZERO;

    wire acs_pkg::acs_src_t src_w =
        (state_ff == acs_pkg::ST_ZERO) ?
            ((mode_ff == `ACS_MODE_SELF) ? acs_pkg::ACS_SRC_SHORTED
                                         : acs_pkg::ACS_SRC_ANALOG) :
        (state_ff == acs_pkg::ST_FULL) ?
            ((mode_ff == `ACS_MODE_SYS_F) ? acs_pkg::ACS_SRC_ANALOG
                                          : acs_pkg::ACS_SRC_REF) :
        (state_ff == acs_pkg::ST_BG && slot_ff == 3'h0) ?
            acs_pkg::ACS_SRC_SHORTED :
        (state_ff == acs_pkg::ST_BG && slot_ff == 3'h1) ?
            acs_pkg::ACS_SRC_REF : acs_pkg::ACS_SRC_ANALOG;

    // full point starts the gain division
    wire logic div_go =
        (state_ff == acs_pkg::ST_FULL && last_conv) ||
        (state_ff == acs_pkg::ST_BG && i_conv_valid && slot_ff == 3'h1);
    // full step alone divides against the stored offset
    wire logic [23:0] base_w =
        (mode_ff == `ACS_MODE_SYS_F) ? coef_ff.offset : zero_ff;
    // Guard against a zero or inverted span
    wire logic [23:0] span_w =
        (i_conv_code > base_w) ? i_conv_code - base_w : 24'h000001;
    wire logic [24:0] rem_sh  = {div_rem_ff, div_num_ff[46]};
    wire logic        fits    = rem_sh >= {1'b0, div_span_ff};
    wire logic [23:0] nxt_rem =
        fits ? 24'(rem_sh - {1'b0, div_span_ff}) : rem_sh[23:0];
    wire logic [23:0] quo_sat =
        (|div_quo_ff[46:24]) ? 24'hffffff : div_quo_ff[23:0];

    // ------------------------------------------------------------
    // Modulator cycle divider and plain registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst || mod_tick) begin
            mod_cnt_ff <= 8'h00;
        end else begin
            mod_cnt_ff <= mod_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            src_ff  <= acs_pkg::ACS_SRC_ANALOG;
            pga_ff  <= 3'h0;
            busy_ff <= 1'b0;
            bg_ff   <= 1'b0;
        end else begin
            src_ff  <= src_w;
            // gain follows the host setting, never overridden
            pga_ff  <= i_gain;
            busy_ff <= (state_ff != acs_pkg::ST_NORMAL);
            bg_ff   <= (state_ff == acs_pkg::ST_BG);
        end
    end

    // ------------------------------------------------------------
    // Gain divider: span target over measured span, 47 steps
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            div_rem_ff  <= 24'h000000;
            div_span_ff <= 24'h000001;
            div_base_ff <= 24'h000000;
            div_num_ff  <= 47'h0;
            div_quo_ff  <= 47'h0;
            div_cnt_ff  <= 6'h00;
            div_busy_ff <= 1'b0;
            div_done_ff <= 1'b0;
        end else begin
            div_done_ff <= 1'b0;
            if (div_go) begin
                div_span_ff <= span_w;
                div_base_ff <= base_w;
                // bipolar spans half the code range
                div_num_ff  <= i_bipolar ? `ACS_NUM_BIP : `ACS_NUM_UNI;
                div_quo_ff  <= 47'h0;
                div_rem_ff  <= 24'h000000;
                div_cnt_ff  <= 6'h2e;
                div_busy_ff <= 1'b1;
            end else if (div_busy_ff) begin
                div_rem_ff <= nxt_rem;
                div_num_ff <= {div_num_ff[45:0], 1'b0};
                div_quo_ff <= {div_quo_ff[45:0], fits};
                div_cnt_ff <= div_cnt_ff - 6'h01;
                if (div_cnt_ff == 6'h00) begin
                    div_busy_ff <= 1'b0;
                    div_done_ff <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_ff    <= acs_pkg::ST_NORMAL;
            mode_ff     <= `ACS_MODE_NONE;
            cnt_ff      <= 3'h0;
            slot_ff     <= 3'h0;
            zero_ff     <= 24'h000000;
            coef_ff     <= {`ACS_OFS_RST, `ACS_GAIN_RST};
            res_ff      <= '0;
            rdy_n_ff    <= 1'b1;
            raise_ff    <= 1'b0;
            frst_ff     <= 1'b0;
            bg_first_ff <= 1'b0;
        end else begin
            frst_ff <= cal_cmd;
            // raise on the next modulator tick
            if (raise_ff && mod_tick) begin
                rdy_n_ff <= 1'b1;
                raise_ff <= 1'b0;
            end
            if (i_result_read) begin
                rdy_n_ff <= 1'b1;
            end
            // host coefficient load, only while idle
            if (!busy_ff && i_coef_wr[0]) begin
                coef_ff.offset <= i_coef_in.offset;
            end
            if (!busy_ff && i_coef_wr[1]) begin
                coef_ff.gain <= i_coef_in.gain;
            end
            // only a mode write changes the mode
            if (i_mode_wr) begin
                mode_ff     <= i_mode;
                state_ff    <= entry_state;
                cnt_ff      <= 3'h0;
                slot_ff     <= 3'h0;
                raise_ff    <= cal_cmd;
                bg_first_ff <= 1'b1;
            end else begin
                unique case (state_ff)
                    acs_pkg::ST_NORMAL: begin
                        // correction; new result beats a read
                        if (i_conv_valid) begin
                            res_ff   <= {corr, 1'b0};
                            rdy_n_ff <= 1'b0;
                        end
                    end
                    acs_pkg::ST_ZERO: begin
                        if (i_conv_valid) begin
                            cnt_ff <= cnt_ff + 3'h1;
                        end
                        if (last_conv) begin
                            cnt_ff  <= 3'h0;
                            zero_ff <= i_conv_code;
                            if (mode_ff == `ACS_MODE_SYS_Z) begin
                                coef_ff.offset <= i_conv_code;
                                rdy_n_ff       <= 1'b0;
                                raise_ff       <= 1'b0;
                                state_ff       <= acs_pkg::ST_NORMAL;
                            end else begin
                                state_ff <= acs_pkg::ST_FULL;
                            end
                        end
                    end
                    acs_pkg::ST_FULL: begin
                        if (i_conv_valid) begin
                            cnt_ff <= cnt_ff + 3'h1;
                        end
                        if (last_conv) begin
                            cnt_ff   <= 3'h0;
                            state_ff <= acs_pkg::ST_DIV;
                        end
                    end
                    acs_pkg::ST_DIV: begin
                        if (div_done_ff) begin
                            coef_ff <= {div_base_ff, quo_sat};
                            if (is_sys) begin
                                rdy_n_ff <= 1'b0;
                                raise_ff <= 1'b0;
                                state_ff <= acs_pkg::ST_NORMAL;
                            end else begin
                                state_ff <= acs_pkg::ST_SETTLE;
                            end
                        end
                    end
                    acs_pkg::ST_SETTLE: begin
                        if (i_conv_valid) begin
                            cnt_ff <= cnt_ff + 3'h1;
                        end
                        if (last_conv) begin
                            cnt_ff   <= 3'h0;
                            rdy_n_ff <= 1'b0;
                            raise_ff <= 1'b0;
                            state_ff <= acs_pkg::ST_NORMAL;
                        end
                    end
                    acs_pkg::ST_BG: begin
                        if (div_done_ff) begin
                            coef_ff <= {div_base_ff, quo_sat};
                        end
                        if (i_conv_valid) begin
                            slot_ff <= bg_last ? 3'h0 : slot_ff + 3'h1;
                            if (slot_ff == 3'h0) begin
                                zero_ff <= i_conv_code;
                            end
                            if (bg_last) begin
                                res_ff      <= {corr, bg_first_ff};
                                bg_first_ff <= 1'b0;
                                rdy_n_ff    <= 1'b0;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign o_data_ready_n = rdy_n_ff;
    assign o_result       = res_ff;
    assign o_coef         = coef_ff;
    assign o_src          = src_ff;
    assign o_pga_gain     = pga_ff;
    assign o_filter_rst   = frst_ff;
    assign o_cal_busy     = busy_ff;
    assign o_bg_active    = bg_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    property p_raise;
        cal_cmd |-> ##[1:258] o_data_ready_n;
    endproperty
    a_raise: assert property (p_raise)
        else $error("data-ready not raised after command");

    property p_frst;
        cal_cmd |=> o_filter_rst ##1 !o_filter_rst;
    endproperty
    a_frst: assert property (p_frst)
        else $error("filter reset pulse missing");

    property p_bad_code;
        (i_mode_wr && !is_cal_code(i_mode)) |=>
            state_ff == acs_pkg::ST_NORMAL && !o_filter_rst;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("unassigned code started a calibration");

    property p_zero_only;
        (state_ff == acs_pkg::ST_ZERO && mode_ff == `ACS_MODE_SYS_Z &&
         last_conv && !i_mode_wr) |=>
            $stable(o_coef.gain) && !o_data_ready_n;
    endproperty
    a_zero_only: assert property (p_zero_only)
        else $error("zero step changed gain");

    property p_order;
        (state_ff == acs_pkg::ST_NORMAL && i_conv_valid && !i_mode_wr &&
         !i_bipolar && i_conv_code == coef_ff.offset) |=>
            o_result.code == 24'h000000;
    endproperty
    a_order: assert property (p_order)
        else $error("offset not removed before gain");

    property p_self_end;
        ($fell(o_data_ready_n) && mode_ff == `ACS_MODE_SELF &&
         $past(state_ff) != acs_pkg::ST_NORMAL && !$past(i_mode_wr)) |->
            $past(state_ff) == acs_pkg::ST_SETTLE;
    endproperty
    a_self_end: assert property (p_self_end)
        else $error("self calibration ended before resettle");

    property p_bg_rate;
        (state_ff == acs_pkg::ST_BG && i_conv_valid && !bg_last) |=>
            $stable(o_result);
    endproperty
    a_bg_rate: assert property (p_bg_rate)
        else $error("background result outside its slot");

    property p_bg_hold;
        (state_ff == acs_pkg::ST_BG && !i_mode_wr) |=>
            state_ff == acs_pkg::ST_BG;
    endproperty
    a_bg_hold: assert property (p_bg_hold)
        else $error("background mode left without mode write");

    property p_self_ref;
        (state_ff == acs_pkg::ST_FULL && mode_ff == `ACS_MODE_SELF &&
         $past(state_ff) == acs_pkg::ST_FULL) |->
            o_src == acs_pkg::ACS_SRC_REF;
    endproperty
    a_self_ref: assert property (p_self_ref)
        else $error("reference node not selected");

    property p_sys_done;
        (state_ff == acs_pkg::ST_DIV && div_done_ff && is_sys &&
         !i_mode_wr) |=> !o_data_ready_n ##1 !o_cal_busy;
    endproperty
    a_sys_done: assert property (p_sys_done)
        else $error("system calibration did not complete");

    c_self: cover property ($fell(o_data_ready_n) &&
                            mode_ff == `ACS_MODE_SELF);
    c_bg: cover property (o_bg_active && $changed(o_result));
    c_sysz: cover property ($fell(o_data_ready_n) &&
                            mode_ff == `ACS_MODE_SYS_Z);
    c_host: cover property (!busy_ff && i_coef_wr != 2'h0);

endmodule

// *** inc/acs_defines.svh ***
// Constants of the calibration sequencer: mode codes, counts, resets.
// Assumes a 100 MHz master clock; included by acs_pkg users and RTL.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Mode field codes
`define ACS_MODE_NONE    3'h0
`define ACS_MODE_SELF    3'h1
`define ACS_MODE_SYS_Z   3'h2
`define ACS_MODE_SYS_F   3'h3
`define ACS_MODE_SYS_OFS 3'h4
`define ACS_MODE_BG      3'h5

// Timing: master clock and modulator cycle in master clocks
`define ACS_MCLK_HZ      100000000
`define ACS_MOD_DIV      256
// Conversions per calibration point, one-step and system modes
`define ACS_PTS_ONE      3
`define ACS_PTS_SYS      4
// Conversion slots per background output
`define ACS_BG_SLOTS     6

// Gain coefficient: fixed point with 22 fraction bits
`define ACS_FRAC         22
`define ACS_OFS_RST      24'h000000
`define ACS_GAIN_RST     24'h400000
`define ACS_MIDSCALE     33'sh000800000
`define ACS_CODE_MAX     33'sh000ffffff
// Span targets shifted by the fraction: 2^46 and 2^45
`define ACS_NUM_UNI      47'h400000000000
`define ACS_NUM_BIP      47'h200000000000

`endif

// *** inc/acs_pkg.sv ***
// Types shared by the calibration sequencer.
// Constants live in acs_defines.svh.
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_SRC_ANALOG,
        ACS_SRC_SHORTED,
        ACS_SRC_REF
    } acs_src_t;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_ZERO,
        ST_FULL,
        ST_DIV,
        ST_SETTLE,
        ST_BG
    } acs_state_t;

    typedef struct packed {
        logic [23:0] offset;
        logic [23:0] gain;
    } acs_coef_t;

    typedef struct packed {
        logic [23:0] code;
        logic        stale;
    } acs_result_t;

endpackage

// *** sim/acs_conv_model.sv ***
// Filter model: one conversion every PER clocks, code chosen by source.
// Assumes the sequencer's filter reset restarts the conversion timer.
`timescale 1ns/100ps
module acs_conv_model #(
    parameter int PER = 60
) (
    input  wire logic              i_mclk,
    input  wire logic              i_filter_rst,
    input  wire acs_pkg::acs_src_t i_src,
    input  wire logic [23:0]       i_ain,
    output logic                   o_valid,
    output logic [23:0]            o_code
);
    int cnt = 0;
    initial o_valid = 1'b0;
    always @(posedge i_mclk) begin
        cnt = i_filter_rst ? 0 : cnt + 1;
        o_valid <= (cnt == PER);
        // Code is only valid with the strobe, so it toggles otherwise
        if (cnt != PER)
            o_code <= ~o_code;
        else if (i_src == acs_pkg::ACS_SRC_SHORTED)
            o_code <= 24'h100000;
        else if (i_src == acs_pkg::ACS_SRC_REF)
            o_code <= 24'h900000;
        else
            o_code <= i_ain;
        if (cnt == PER)
            cnt = 0;
    end
endmodule

// *** sim/adc_calibration_sequencer_tb.sv ***
// Self-checking bench of the calibration sequencer.
// Assumes acs_defines.svh on the include path; MOD_DIV shortened to 8.
`timescale 1ns/100ps
`include "acs_defines.svh"
module adc_calibration_sequencer_tb;
    localparam int MD = 8;
    logic                 i_mclk = 1'b0;
    logic                 i_srst = 1'b1;
    logic                 i_mode_wr = 1'b0;
    logic [2:0]           i_mode = 3'h0;
    logic [1:0]           i_coef_wr = 2'h0;
    acs_pkg::acs_coef_t   i_coef_in = '0;
    logic                 i_result_read = 1'b0;
    logic                 i_bipolar = 1'b0;
    logic                 i_word24 = 1'b1;
    logic [2:0]           i_gain = 3'h2;
    logic                 i_conv_valid;
    logic [23:0]          i_conv_code;
    logic [23:0]          analog_input = 24'h000100;
    logic                 o_data_ready_n, o_filter_rst, o_cal_busy;
    logic                 o_bg_active;
    logic [2:0]           o_pga_gain;
    acs_pkg::acs_result_t o_result;
    acs_pkg::acs_coef_t   o_coef;
    acs_pkg::acs_src_t    o_src;
    int                   err_total = 0, n_tests = 0, cyc = 0;

    acs_seq #(.MOD_DIV(MD)) i_dut (.i_mclk, .i_srst, .i_mode_wr, .i_mode,
        .i_bipolar, .i_word24, .i_gain, .i_coef_wr,
        .i_coef_in, .i_conv_valid, .i_conv_code, .i_result_read,
        .o_data_ready_n, .o_result, .o_coef, .o_src, .o_pga_gain,
        .o_filter_rst, .o_cal_busy, .o_bg_active);
    acs_conv_model i_model (.i_mclk, .i_filter_rst(o_filter_rst),
        .i_src(o_src), .i_ain(analog_input), .o_valid(i_conv_valid),
        .o_code(i_conv_code));

    always #5 i_mclk = ~i_mclk;
    // Cut a hang short well past the expected run length
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic mode_wr(input logic [2:0] md, output logic fr);
        @(negedge i_mclk);
        i_mode_wr = 1'b1;
        i_mode = md;
        @(negedge i_mclk);
        i_mode_wr = 1'b0;
        fr = o_filter_rst;
        @(negedge i_mclk);
        fr = fr | o_filter_rst;
    endtask
    task automatic read_next(output int k);
        int n = 0;
        k = 0;
        @(negedge i_mclk);
        i_result_read = 1'b1;
        @(negedge i_mclk);
        i_result_read = 1'b0;
        while (o_data_ready_n !== 1'b0 && n < 500) begin
            @(negedge i_mclk);
            n++;
            if (i_conv_valid)
                k++;
        end
    endtask
    task automatic cal(input logic [2:0] md);
        logic fr;
        int n = 0;
        mode_wr(md, fr);
        check(fr, 1'b1);
        while (o_data_ready_n !== 1'b1 && n < MD + 2) begin
            @(negedge i_mclk);
            n++;
        end
        check(o_data_ready_n, 1'b1);
        while (o_cal_busy !== 1'b0 && n < 3000) begin
            @(negedge i_mclk);
            n++;
        end
        repeat (2) @(negedge i_mclk);
        check(o_data_ready_n, 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_coef();
        int k;
        @(negedge i_mclk);
        i_coef_wr = 2'h1;
        i_coef_in = {24'h000010, 24'h123456};
        @(negedge i_mclk);
        i_coef_wr = 2'h0;
        check(o_coef, {24'h000010, 24'h400000});
        read_next(k);
        check(o_result.code, 24'h0000f0);
        i_word24 = 1'b0;
        read_next(k);
        check(o_result.code, 24'h000000);
        i_word24 = 1'b1;
        i_coef_wr = 2'h2;
        @(negedge i_mclk);
        i_coef_wr = 2'h0;
        check(o_coef, {24'h000010, 24'h123456});
        check(o_pga_gain, 3'h2);
    endtask
    task automatic t_self();
        int k;
        analog_input = 24'h500000;
        i_gain = 3'h5;
        i_bipolar = 1'b1;
        cal(3'h1);
        check(o_coef, {24'h100000, 24'h400000});
        check(o_pga_gain, 3'h5);
        read_next(k);
        check(o_result.code, 24'hc00000);
        i_bipolar = 1'b0;
    endtask
    task automatic t_sys();
        analog_input = 24'h100000;
        cal(3'h2);
        check(o_coef, {24'h100000, 24'h400000});
        analog_input = 24'hd00000;
        cal(3'h3);
        check(o_coef, {24'h100000, 24'h555555});
        analog_input = 24'h200000;
        cal(3'h2);
        check(o_coef, {24'h200000, 24'h555555});
        analog_input = 24'h500000;
        cal(3'h4);
        check(o_coef, {24'h500000, 24'hffffff});
    endtask
    task automatic t_unassigned();
        logic fr;
        mode_wr(3'h6, fr);
        check(fr, 1'b0);
        check(o_cal_busy, 1'b0);
    endtask
    task automatic t_bg();
        logic fr;
        int k;
        mode_wr(3'h5, fr);
        check(fr, 1'b1);
        read_next(k);
        check(o_result.stale, 1'b1);
        check(o_bg_active, 1'b1);
        read_next(k);
        check(48'(k), 48'h6);
        check(o_result.stale, 1'b0);
        mode_wr(3'h0, fr);
        check(o_bg_active, 1'b0);
    endtask

    initial begin
        repeat (10) @(negedge i_mclk);
        i_srst = 1'b0;
        check(o_coef, {`ACS_OFS_RST, `ACS_GAIN_RST});
        check(o_data_ready_n, 1'b1);
        t_coef();
        t_unassigned();
        t_self();
        t_sys();
        t_bg();
        wrap_up();
    end
endmodule
